// *** core/scc_pkg.sv ***
package scc_pkg;
	// Register offsets (printed offsets 0x04, 0x05 are indices; byte address = 4*index)
	localparam logic [7:0] TIMING_IDX = 8'h04;
	localparam logic [7:0] AUX_IDX = 8'h05;
	localparam logic [11:0] TIMING_ADDR = 12'h010;
	localparam logic [11:0] AUX_ADDR = 12'h014;
	// Field positions
	localparam int FREQ_LSB = 4;
	localparam int FREQ_MSB = 7;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 2;
	localparam int PERMIT_BIT = 1;
	localparam int LONLY_BIT = 0;
	// Reset values
	localparam logic [3:0] FREQ_RST = 4'h0;
	localparam logic [2:0] SEL_RST = 3'h3;
	localparam logic PERMIT_RST = 1'b0;
	localparam logic LONLY_RST = 1'b0;
	// Sensor period counts per conversion
	localparam logic [12:0] PER_192 = 13'h00c0;
	localparam logic [12:0] PER_384 = 13'h0180;
	localparam logic [12:0] PER_768 = 13'h0300;
	localparam logic [12:0] PER_1536 = 13'h0600;
	localparam logic [12:0] PER_3072 = 13'h0c00;
	localparam logic [12:0] PER_6144 = 13'h1800;
	// Conversion length in sensor-derived ticks: periods divided by three
	localparam logic [1:0] DIV_BY = 2'h3;
	// Frequency code formula constants
	localparam logic [4:0] FREQ_BASE = 5'h10;
	localparam int CLK_HZ = 25000000;
	// Conversion sequencer states
	typedef enum logic [2:0] {
		SCC_IDLE = 3'b001,
		SCC_RES = 3'b010,
		SCC_IND = 3'b100
	} scc_state_t;
endpackage

// *** core/scc_config.sv ***
`timescale 1ns/1ps
// Contract
// RULE_01 - Minimum frequency code at bits 7:4, reset zero, code = 16 - 8MHz/fmin.
// RULE_02 - Software picks minimum frequency code with margin for temperature and tolerance.
// RULE_03 - Software writes zeros to reserved bits of both registers.
// RULE_04 - Period select at bits 2:0, reset b011 = 384; table of counts.
// RULE_05 - Software never writes period select codes b000 or b001.
// RULE_06 - Period select affects resistance and standard inductance only, never fine path.
// RULE_07 - Conversion lasts selected periods divided by three times sensor frequency.
// RULE_08 - Code b100 selects 768 periods.
// RULE_09 - Power-off permit at bit 1, reset zero; zero blocks power-off request.
// RULE_10 - Inductance-only drive skips resistance conversion; resistance results invalid.
// RULE_11 - Software sets ready-report select whenever inductance-only drive is set.
// RULE_12 - With inductance-only drive clear, resistance and inductance conversions both run.
module scc_config (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sensor timing and power control
	input wire logic sensor_tick,
	input wire logic fine_tick,
	input wire logic power_off_request,
	output logic power_off,
	output logic [3:0] lowest_sensor_freq_code,
	// Conversion results status
	output logic res_done,
	output logic res_valid,
	output logic ind_done,
	output logic fine_done
);

	logic [3:0] freq_code;
	logic [2:0] sel;
	logic permit;
	logic lonly;
	logic [12:0] tick_cnt;
	logic [12:0] fine_cnt;
	scc_pkg::scc_state_t state;
	scc_pkg::scc_state_t next_state;

	// Bus decode
	wire access = psel & penable & clk_en;
	wire hit_timing = paddr == scc_pkg::TIMING_ADDR;
	wire hit_aux = paddr == scc_pkg::AUX_ADDR;
	wire mapped = hit_timing | hit_aux;
	wire wr_timing = access & pwrite & hit_timing & pstrb[0];
	wire wr_aux = access & pwrite & hit_aux & pstrb[0];
	wire [31:0] rd_mux = hit_timing ? {24'h000000, freq_code, 1'b0, sel} :
		hit_aux ? {30'h00000000, permit, lonly} : 32'h00000000;

	// Period count selection, b100 taken as 768
	logic [12:0] periods;
	always_comb begin
		unique case (sel)
			3'h2: periods = scc_pkg::PER_192; // RULE_04
			3'h3: periods = scc_pkg::PER_384; // RULE_04
			3'h4: periods = scc_pkg::PER_768; // RULE_08
			3'h5: periods = scc_pkg::PER_1536; // RULE_04
			3'h6: periods = scc_pkg::PER_3072; // RULE_04
			3'h7: periods = scc_pkg::PER_6144; // RULE_04
			default: periods = scc_pkg::PER_384; // Reserved codes fall back
		endcase
	end

	// Conversion spans periods / 3 sensor periods, one count per sensor_tick
	wire [12:0] conv_len = periods / 13'(scc_pkg::DIV_BY); // RULE_07
	wire conv_end = sensor_tick & (tick_cnt == conv_len - 13'h0001);

	// Register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_code <= scc_pkg::FREQ_RST; // RULE_01
			sel <= scc_pkg::SEL_RST; // RULE_04
			permit <= scc_pkg::PERMIT_RST; // RULE_09
			lonly <= scc_pkg::LONLY_RST; // RULE_12
		end else if (wr_timing) begin
			freq_code <= pwdata[scc_pkg::FREQ_MSB:scc_pkg::FREQ_LSB]; // RULE_01
			sel <= pwdata[scc_pkg::SEL_MSB:scc_pkg::SEL_LSB];
		end else if (wr_aux) begin
			permit <= pwdata[scc_pkg::PERMIT_BIT];
			lonly <= pwdata[scc_pkg::LONLY_BIT];
		end
	end

	// APB answer, zero wait states
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			scc_pkg::SCC_IDLE: next_state = lonly ? scc_pkg::SCC_IND : scc_pkg::SCC_RES; // RULE_10
			scc_pkg::SCC_RES: next_state = conv_end ? scc_pkg::SCC_IND : scc_pkg::SCC_RES; // RULE_12
			scc_pkg::SCC_IND: next_state = conv_end ? scc_pkg::SCC_IDLE : scc_pkg::SCC_IND;
		endcase
	end

	// Sequencer and tick counters
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= scc_pkg::SCC_IDLE;
			tick_cnt <= 13'h0000;
		end else if (clk_en) begin
			state <= next_state;
			if (state == scc_pkg::SCC_IDLE || conv_end) begin
				tick_cnt <= 13'h0000;
			end else if (sensor_tick) begin
				tick_cnt <= tick_cnt + 13'h0001; // RULE_07
			end
		end
	end

	// Fine path runs on its own fixed count, independent of period select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fine_cnt <= 13'h0000;
			fine_done <= 1'b0;
		end else if (clk_en) begin
			fine_done <= fine_tick & (fine_cnt == scc_pkg::PER_6144 - 13'h0001); // RULE_06
			if (fine_tick) begin
				fine_cnt <= (fine_cnt == scc_pkg::PER_6144 - 13'h0001) ? 13'h0000 :
					fine_cnt + 13'h0001;
			end
		end
	end

	// Result strobes, power control and code output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res_done <= 1'b0;
			res_valid <= 1'b0;
			ind_done <= 1'b0;
			power_off <= 1'b0;
			lowest_sensor_freq_code <= scc_pkg::FREQ_RST;
		end else if (clk_en) begin
			res_done <= conv_end & (state == scc_pkg::SCC_RES); // RULE_06
			ind_done <= conv_end & (state == scc_pkg::SCC_IND);
			if (conv_end & (state == scc_pkg::SCC_RES)) begin
				res_valid <= 1'b1;
			end else if (lonly) begin
				res_valid <= 1'b0; // RULE_10
			end
			power_off <= permit & power_off_request; // RULE_09
			lowest_sensor_freq_code <= freq_code;
		end
	end

	// Assertions
	property p_permit_gate;
		@(posedge clk) disable iff (!rst_n)
		clk_en & ~permit |=> ~power_off;
	endproperty
	a_permit_gate: assert property (p_permit_gate) else $error("power off without permit"); // RULE_09

	property p_lonly_invalid;
		@(posedge clk) disable iff (!rst_n)
		clk_en & lonly & (state != scc_pkg::SCC_RES) |=> ~res_valid & ~res_done;
	endproperty
	a_lonly_invalid: assert property (p_lonly_invalid) else $error("resistance valid in L-only"); // RULE_10

	property p_sel_reset;
		@(posedge clk) $rose(rst_n) |-> sel == 3'h3 && freq_code == 4'h0 && !permit && !lonly;
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("bad reset value"); // RULE_04

	property p_b100;
		@(posedge clk) disable iff (!rst_n)
		sel == 3'h4 |-> periods == 13'h0300;
	endproperty
	a_b100: assert property (p_b100) else $error("code b100 not 768"); // RULE_08

	property p_len;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |-> conv_len * 13'h0003 == periods;
	endproperty
	a_len: assert property (p_len) else $error("length not periods over three"); // RULE_07

	property p_both;
		@(posedge clk) disable iff (!rst_n)
		clk_en & ~lonly & (state == scc_pkg::SCC_IDLE) |=> state == scc_pkg::SCC_RES;
	endproperty
	a_both: assert property (p_both) else $error("resistance skipped"); // RULE_12

	property p_code_out;
		@(posedge clk) disable iff (!rst_n)
		clk_en & wr_timing ##1 clk_en |=> lowest_sensor_freq_code == $past(pwdata[7:4], 2);
	endproperty
	a_code_out: assert property (p_code_out) else $error("freq code not stored"); // RULE_01

	property p_fine;
		@(posedge clk) disable iff (!rst_n)
		fine_done |-> $past(fine_cnt) == 13'h17ff;
	endproperty
	a_fine: assert property (p_fine) else $error("fine timing moved"); // RULE_06

	// Bus answer shape: one-cycle ready, error only on unmapped words
	property p_pready_pulse;
		@(posedge clk) disable iff (!rst_n)
		clk_en & pready & penable |=> ~pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");

	property p_err_unmapped;
		@(posedge clk) disable iff (!rst_n)
		clk_en & psel & ~penable & ~mapped |=> pready & pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");

	property p_err_mapped;
		@(posedge clk) disable iff (!rst_n)
		clk_en & psel & ~penable & mapped |=> pready & ~pslverr;
	endproperty
	a_err_mapped: assert property (p_err_mapped) else $error("error on mapped word");

	// Reserved bits always read back as zero
	property p_rd_timing;
		@(posedge clk) disable iff (!rst_n)
		clk_en & psel & ~penable & ~pwrite & hit_timing |=>
			prdata[3] == 1'b0 && prdata[31:8] == 24'h000000;
	endproperty
	a_rd_timing: assert property (p_rd_timing) else $error("timing reserved bits set");

	property p_rd_aux;
		@(posedge clk) disable iff (!rst_n)
		clk_en & psel & ~penable & ~pwrite & hit_aux |=> prdata[31:2] == 30'h00000000;
	endproperty
	a_rd_aux: assert property (p_rd_aux) else $error("aux reserved bits set");

	// Register writes land and masked writes do not
	property p_wr_strb;
		@(posedge clk) disable iff (!rst_n)
		access & pwrite & hit_timing & ~pstrb[0] |=> $stable(sel) && $stable(freq_code);
	endproperty
	a_wr_strb: assert property (p_wr_strb) else $error("masked write changed field");

	property p_wr_timing;
		@(posedge clk) disable iff (!rst_n)
		wr_timing |=> sel == $past(pwdata[2:0]) && freq_code == $past(pwdata[7:4]);
	endproperty
	a_wr_timing: assert property (p_wr_timing) else $error("timing write lost"); // RULE_04

	property p_wr_aux;
		@(posedge clk) disable iff (!rst_n)
		wr_aux |=> permit == $past(pwdata[1]) && lonly == $past(pwdata[0]);
	endproperty
	a_wr_aux: assert property (p_wr_aux) else $error("aux write lost"); // RULE_09

	// Power-off follows the request once permitted
	property p_permit_on;
		@(posedge clk) disable iff (!rst_n)
		clk_en & permit & power_off_request |=> power_off;
	endproperty
	a_permit_on: assert property (p_permit_on) else $error("permitted request ignored"); // RULE_09

	// Sequencer order and conversion lengths
	property p_lonly_skip;
		@(posedge clk) disable iff (!rst_n)
		clk_en & lonly & (state == scc_pkg::SCC_IDLE) |=> state == scc_pkg::SCC_IND;
	endproperty
	a_lonly_skip: assert property (p_lonly_skip) else $error("resistance not skipped"); // RULE_10

	property p_idle_brief;
		@(posedge clk) disable iff (!rst_n)
		clk_en & (state == scc_pkg::SCC_IDLE) |=> state != scc_pkg::SCC_IDLE;
	endproperty
	a_idle_brief: assert property (p_idle_brief) else $error("sequencer stuck idle");

	property p_res_len;
		@(posedge clk) disable iff (!rst_n)
		res_done & $past(clk_en) |-> $past(tick_cnt) == $past(conv_len) - 13'h0001;
	endproperty
	a_res_len: assert property (p_res_len) else $error("resistance length wrong"); // RULE_07

	property p_ind_len;
		@(posedge clk) disable iff (!rst_n)
		ind_done & $past(clk_en) |-> $past(tick_cnt) == $past(conv_len) - 13'h0001;
	endproperty
	a_ind_len: assert property (p_ind_len) else $error("inductance length wrong"); // RULE_07

	// Output copy of the code and fine strobe shape
	property p_code_copy;
		@(posedge clk) disable iff (!rst_n)
		clk_en |=> lowest_sensor_freq_code == $past(freq_code);
	endproperty
	a_code_copy: assert property (p_code_copy) else $error("code output stale"); // RULE_01

	property p_fine_pulse;
		@(posedge clk) disable iff (!rst_n)
		clk_en & fine_done |=> ~fine_done;
	endproperty
	a_fine_pulse: assert property (p_fine_pulse) else $error("fine strobe held"); // RULE_06

	c_res: cover property (@(posedge clk) res_done);
	c_ind: cover property (@(posedge clk) ind_done);
	c_off: cover property (@(posedge clk) power_off);
	c_fine: cover property (@(posedge clk) fine_done);
	c_lonly: cover property (@(posedge clk) ind_done & lonly);

endmodule // scc_config

// *** bench/sensor_conversion_config_bench.sv ***
`timescale 1ns/1ps
module sensor_conversion_config_bench;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic req = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, power_off, res_done, res_valid, ind_done, fine_done, er;
	logic [3:0] freq;
	int num_errors = 0;
	int check_count = 0;
	int n, nr, ni;
	int per [6] = '{64, 128, 256, 512, 1024, 2048};
	// Clock
	always #20 clk = ~clk;
	// Device under test
	scc_config dut (.clk(clk), .rst_n(rst_n), .clk_en(1'h1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sensor_tick(1'h1), .fine_tick(1'h1),
		.power_off_request(req), .power_off(power_off), .lowest_sensor_freq_code(freq),
		.res_done(res_done), .res_valid(res_valid), .ind_done(ind_done), .fine_done(fine_done));
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	// Edges from a pulse on one output to the next pulse on another
	task automatic gap(ref logic a, ref logic b, output int c);
		c = 0;
		do @(posedge clk); while (a !== 1'h1);
		do begin
			@(posedge clk);
			c++;
		end while (b !== 1'h1 && c < 9000);
	endtask
	// Verdict
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		summarize();
	end
	// Test sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		apb(1'h0, scc_pkg::TIMING_ADDR, 32'h0);
		chk(rd, 32'h3);
		chk(freq, 32'h0);
		apb(1'h0, scc_pkg::AUX_ADDR, 32'h0);
		chk(rd, 32'h0);
		apb(1'h0, 12'h018, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		apb(1'h1, scc_pkg::TIMING_ADDR, 32'ha5);
		apb(1'h0, scc_pkg::TIMING_ADDR, 32'h0);
		chk(rd, 32'ha5);
		chk(freq, 32'ha);
		// Shutdown request is ignored until permitted
		req <= 1'h1;
		repeat (3) @(posedge clk);
		chk(power_off, 32'h0);
		apb(1'h1, scc_pkg::AUX_ADDR, 32'h2);
		repeat (3) @(posedge clk);
		chk(power_off, 32'h1);
		// Every legal period code, second conversion after the change
		for (int i = 0; i < 6; i++) begin
			apb(1'h1, scc_pkg::TIMING_ADDR, {29'h0, 3'(i + 2)});
			gap(res_done, ind_done, n);
			gap(res_done, ind_done, n);
			chk(n, per[i]);
		end
		chk(res_valid, 32'h1);
		gap(fine_done, fine_done, n);
		chk(n, 32'd6144);
		// Inductance-only drive: no resistance results
		apb(1'h1, scc_pkg::AUX_ADDR, 32'h3);
		gap(ind_done, ind_done, n);
		nr = 0;
		ni = 0;
		repeat (5000) begin
			@(posedge clk);
			nr += int'(res_done === 1'h1);
			ni += int'(ind_done === 1'h1);
		end
		chk(nr, 32'h0);
		chk(ni != 0, 32'h1);
		chk(res_valid, 32'h0);
		summarize();
	end
endmodule // sensor_conversion_config_bench
